//--- logic/bsctap_pkg.sv
// shared constants, states and carriers of the boundary scan tap
// assumes one system clock samples every tap pin
package bsctap_pkg;
    localparam int IR_WIDTH = 4;
    localparam int ID_WIDTH = 32;
    localparam int CELLS_PER_IO = 3;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;
    localparam logic [IR_WIDTH-1:0] INSTR_EXTEST = 4'h0;
    localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE = 4'h1;
    localparam logic [IR_WIDTH-1:0] INSTR_IDCODE = 4'hE;
    localparam logic [IR_WIDTH-1:0] INSTR_BYPASS = 4'hF;
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;
    // identification fields, values arbitrary
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART = 16'h0A5A;
    localparam logic [10:0] ID_NUMBER = 11'h123;
    localparam logic ID_LSB = 1'b1;
    localparam int TMS_RESET_CYCLES = 5;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } bsctap_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trstN;
    } bsctap_pins_t;

    localparam bsctap_pins_t PINS_IDLE = 4'h1;

    typedef struct packed {
        logic data;
        logic drive;
    } bsctap_tdo_t;
endpackage : bsctap_pkg

//--- logic/bsctap_fifo.sv
// first-in first-out buffer with valid and ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module bsctap_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic doWrite;
    logic doRead;

    assign inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign outData = mem[rdPtr[AW-1:0]];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    always_ff @(posedge sys_clk)
    begin
        if (doWrite)
        begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
        end
        else
        begin
            if (doWrite)
            begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead)
            begin
                rdPtr <= rdPtr + 1'b1;
            end
        end
    end
endmodule : bsctap_fifo

//--- logic/bsctap_top.sv
// boundary scan test access port: state machine, instruction and data registers
// assumes tck, tms, tdi, trst arrive from pins asynchronous to sys_clk
`timescale 1ns/10ps
module bsctap_top
    import bsctap_pkg::*;
#(
    parameter int NUM_IO = 8,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire bsctap_pkg::bsctap_pins_t pins,
    output logic tdo,
    output logic tdoOe_n,
    input wire logic [NUM_IO-1:0] coreOut,
    input wire logic [NUM_IO-1:0] coreOe,
    output logic [NUM_IO-1:0] coreIn,
    input wire logic [NUM_IO-1:0] padIn,
    output logic [NUM_IO-1:0] padOut,
    output logic [NUM_IO-1:0] padOe_n,
    output logic testReset
);
    import bsctap_pkg::*;

    localparam int BSR_LEN = NUM_IO * CELLS_PER_IO;
    localparam logic [ID_WIDTH-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_NUMBER, ID_LSB};

    bsctap_pins_t sync1;
    bsctap_pins_t sync2;
    bsctap_pins_t sync3;
    bsctap_pins_t pinLevel;
    logic tckPrev;
    logic tckRise;
    logic tckFall;
    logic step;
    logic pushPending;
    bsctap_state_t state;
    bsctap_state_t next_state;
    logic [IR_WIDTH-1:0] irShift;
    logic [IR_WIDTH-1:0] instr;
    logic bypassBit;
    logic [ID_WIDTH-1:0] idShift;
    logic [BSR_LEN-1:0] bsrShift;
    logic [BSR_LEN-1:0] bsrHold;
    logic [BSR_LEN-1:0] bsrCapture;
    logic selId;
    logic selBsr;
    logic extestOn;
    logic serialBit;
    logic shiftingNow;
    bsctap_tdo_t fifoIn;
    bsctap_tdo_t fifoOut;
    logic fifoInReady;
    logic fifoOutValid;

    // three-stage sampling, level accepted when stages two and three agree
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            sync1 <= PINS_IDLE;
            sync2 <= PINS_IDLE;
            sync3 <= PINS_IDLE;
            pinLevel <= PINS_IDLE;
            tckPrev <= 1'b0;
        end
        else
        begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
            pinLevel <= (~(sync2 ^ sync3) & sync2) | ((sync2 ^ sync3) & pinLevel);
            tckPrev <= pinLevel.tck;
        end
    end

    assign tckRise = pinLevel.tck && !tckPrev;
    assign tckFall = !pinLevel.tck && tckPrev;
    // a pending serial word masks any tck rise that comes before it is pushed
    assign step = tckRise && !pushPending;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !pinLevel.trstN)
        begin
            state <= TEST_LOGIC_RESET;
        end
        else if (step)
        begin
            state <= next_state;
        end
    end

    // tms high walks every state to test-logic-reset within five steps
    always_comb
    begin
        next_state = state;
        case (state)
            TEST_LOGIC_RESET: next_state = pinLevel.tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE: next_state = pinLevel.tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR: next_state = pinLevel.tms ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR: next_state = pinLevel.tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_state = pinLevel.tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_state = pinLevel.tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: next_state = pinLevel.tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_state = pinLevel.tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: next_state = pinLevel.tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR: next_state = pinLevel.tms ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR: next_state = pinLevel.tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_state = pinLevel.tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_state = pinLevel.tms ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: next_state = pinLevel.tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_state = pinLevel.tms ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: next_state = pinLevel.tms ? SELECT_DR : RUN_TEST_IDLE;
            default: next_state = TEST_LOGIC_RESET;
        endcase
    end

    assign selId = instr == INSTR_IDCODE;
    assign selBsr = (instr == INSTR_EXTEST) || (instr == INSTR_SAMPLE);
    assign extestOn = instr == INSTR_EXTEST;

    // instruction path
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || state == TEST_LOGIC_RESET)
        begin
            irShift <= IR_CAPTURE;
            instr <= INSTR_IDCODE;
        end
        else if (step)
        begin
            case (state)
                CAPTURE_IR: irShift <= IR_CAPTURE;
                SHIFT_IR: irShift <= {pinLevel.tdi, irShift[IR_WIDTH-1:1]};
                UPDATE_IR: instr <= irShift;
                default: irShift <= irShift;
            endcase
        end
    end

    // bypass register, in the path for every instruction but id and boundary
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            bypassBit <= 1'b0;
        end
        else if (step && !selId && !selBsr)
        begin
            case (state)
                CAPTURE_DR: bypassBit <= 1'b0;
                SHIFT_DR: bypassBit <= pinLevel.tdi;
                default: bypassBit <= bypassBit;
            endcase
        end
    end

    // identification register
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            idShift <= ID_VALUE;
        end
        else if (step && selId)
        begin
            case (state)
                CAPTURE_DR: idShift <= ID_VALUE;
                SHIFT_DR: idShift <= {pinLevel.tdi, idShift[ID_WIDTH-1:1]};
                default: idShift <= idShift;
            endcase
        end
    end

    // parallel inputs of the three cells per io
    always_comb
    begin
        bsrCapture = '0;
        for (int i = 0; i < NUM_IO; i++)
        begin
            bsrCapture[i*CELLS_PER_IO + CELL_IN] = padIn[i];
            bsrCapture[i*CELLS_PER_IO + CELL_OUT] = coreOut[i];
            bsrCapture[i*CELLS_PER_IO + CELL_OE] = coreOe[i];
        end
    end

    // boundary scan shift and hold stages
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            bsrShift <= '0;
            bsrHold <= '0;
        end
        else if (step && selBsr)
        begin
            case (state)
                CAPTURE_DR: bsrShift <= bsrCapture;
                SHIFT_DR: bsrShift <= {pinLevel.tdi, bsrShift[BSR_LEN-1:1]};
                UPDATE_DR: bsrHold <= bsrShift;
                default: bsrShift <= bsrShift;
            endcase
        end
    end

    // parallel outputs: pads follow the hold stage during external test
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            padOut <= '0;
            padOe_n <= '1;
            coreIn <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_IO; i++)
            begin
                padOut[i] <= extestOn ? bsrHold[i*CELLS_PER_IO + CELL_OUT] : coreOut[i];
                padOe_n[i] <= extestOn ? !bsrHold[i*CELLS_PER_IO + CELL_OE] : !coreOe[i];
                coreIn[i] <= padIn[i];
            end
        end
    end

    // serial output selection, one cycle after the edge that moved the registers
    always_comb
    begin
        shiftingNow = (state == SHIFT_DR) || (state == SHIFT_IR);
        serialBit = (state == SHIFT_IR) ? irShift[0] :
            selId ? idShift[0] : selBsr ? bsrShift[0] : bypassBit;
        fifoIn.data = serialBit;
        fifoIn.drive = shiftingNow;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !pinLevel.trstN)
        begin
            pushPending <= 1'b0;
        end
        else if (step)
        begin
            pushPending <= 1'b1;
        end
        else if (fifoInReady)
        begin
            pushPending <= 1'b0;
        end
    end

    bsctap_fifo #(
        .WIDTH($bits(bsctap_tdo_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n && pinLevel.trstN),
        .inValid(pushPending),
        .inReady(fifoInReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(tckFall),
        .outData(fifoOut)
    );

    // tdo moves only on a tck falling edge or on a reset
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !pinLevel.trstN)
        begin
            tdo <= 1'b0;
            tdoOe_n <= 1'b1;
        end
        else if (tckFall)
        begin
            tdo <= fifoOutValid && fifoOut.data;
            tdoOe_n <= !(fifoOutValid && fifoOut.drive);
        end
    end

    assign testReset = state == TEST_LOGIC_RESET;
endmodule : bsctap_top

//--- verification/bsctap_top_monitor.sv
// port-level checks of the boundary scan tap, bound into bsctap_top
// assumes sys_clk samples the tap pins and reset_n is synchronous
`timescale 1ns/10ps
module bsctap_top_monitor
#(
    parameter int NUM_IO = 8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire bsctap_pkg::bsctap_pins_t pins,
    input wire logic tdo,
    input wire logic tdoOe_n,
    input wire logic [NUM_IO-1:0] coreOut,
    input wire logic [NUM_IO-1:0] coreOe,
    input wire logic [NUM_IO-1:0] coreIn,
    input wire logic [NUM_IO-1:0] padIn,
    input wire logic [NUM_IO-1:0] padOut,
    input wire logic [NUM_IO-1:0] padOe_n,
    input wire logic testReset
);
    import bsctap_pkg::*;
    logic tckSeen;
    logic [3:0] sinceFall;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge sys_clk)
    begin
        tckSeen <= reset_n ? pins.tck : 1'b0;
    end
    // cycles since the tck pin last fell
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            sinceFall <= 4'hF;
        else if (tckSeen && !pins.tck)
            sinceFall <= 4'h0;
        else if (sinceFall != 4'hF)
            sinceFall <= sinceFall + 4'h1;
    end
    a_reset_values: assert property (disable iff (1'b0) !reset_n |=> testReset && tdoOe_n && padOe_n == '1)
        else $error("reset values wrong");
    a_core_in_copy: assert property (coreIn == $past(padIn))
        else $error("core input not one cycle behind pad");
    a_trst_forces: assert property (!pins.trstN [*7] |-> testReset)
        else $error("trst did not reach reset state");
    a_tdo_after_fall: assert property ($changed(tdo) |-> sinceFall inside {[2:6]} || !pins.trstN)
        else $error("tdo changed away from a tck fall");
    a_oe_fall_timing: assert property ($fell(tdoOe_n) |-> sinceFall inside {[2:6]})
        else $error("tdo enable rose away from a tck fall");
    a_oe_rise_timing: assert property ($rose(tdoOe_n) |-> sinceFall inside {[2:6]} || !pins.trstN)
        else $error("tdo disable away from a tck fall");
    a_oe_off_reset: assert property (testReset |-> tdoOe_n)
        else $error("tdo driven in reset state");
    a_tms_keeps_reset: assert property ((testReset && pins.tms) [*6] |=> testReset)
        else $error("reset state left with tms high");
    a_pads_pass: assert property (testReset && $past(testReset) |=>
        padOut == $past(coreOut) && padOe_n == ~$past(coreOe))
        else $error("pads not following core in reset state");
    c_shift: cover property ($fell(tdoOe_n));
    c_reset: cover property ($rose(testReset));
    c_pads: cover property ($changed(padOut));
endmodule : bsctap_top_monitor
bind bsctap_top bsctap_top_monitor #(.NUM_IO(NUM_IO)) bsctap_top_monitor_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .pins(pins), .tdo(tdo), .tdoOe_n(tdoOe_n), .coreOut(coreOut),
    .coreOe(coreOe), .coreIn(coreIn), .padIn(padIn), .padOut(padOut), .padOe_n(padOe_n),
    .testReset(testReset));

//--- verification/bsctap_host_model.sv
// test controller model driving the tap pins, one tck period per tick call
// assumes sys_clk at 100 ns; tck period is eight sys_clk, idle low
`timescale 1ns/10ps
module bsctap_host_model (
    input wire logic sys_clk,
    input wire logic tdo,
    input wire logic tdoOe_n,
    output bsctap_pkg::bsctap_pins_t pins,
    output logic seen,
    output logic [1:0] seenVal
);
    import bsctap_pkg::*;
    logic watchPrev;
    initial
    begin
        pins = PINS_IDLE;
        seen = 1'b0;
        seenVal = 2'h0;
        watchPrev = 1'b0;
    end
    // tms and tdi settle three cycles before the rise, period eight cycles
    // output of the previous bit is sampled in the high phase
    task automatic tick(input logic tmsV, input logic tdiV, input logic watch);
        @(negedge sys_clk);
        pins.tms = tmsV;
        pins.tdi = tdiV;
        repeat (3) @(negedge sys_clk);
        pins.tck = 1'b1;
        repeat (3) @(negedge sys_clk);
        seenVal = {tdoOe_n, tdo};
        seen = watchPrev;
        @(negedge sys_clk);
        seen = 1'b0;
        pins.tck = 1'b0;
        watchPrev = watch;
    endtask : tick
    task automatic hold_trst(input int cycles);
        @(negedge sys_clk);
        pins.trstN = 1'b0;
        repeat (cycles) @(negedge sys_clk);
        pins.trstN = 1'b1;
    endtask : hold_trst
endmodule : bsctap_host_model

//--- verification/bsctap_top_tb_top.sv
// self-checking bench of the boundary scan tap with a controller model
// assumes the design's package constants for codes and identification
`timescale 1ns/10ps
module bsctap_top_tb_top;
    import bsctap_pkg::*;
    localparam int NIO = 8;
    localparam int BSR = CELLS_PER_IO * NIO;
    localparam logic [63:0] IDV = {32'h0, ID_VERSION, ID_PART, ID_NUMBER, ID_LSB};
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    bsctap_pins_t pins;
    logic tdo, tdoOe_n, testReset, seen;
    logic [1:0] seenVal;
    logic [NIO-1:0] coreOut = '0, coreOe = '0, padIn = '0;
    logic [NIO-1:0] coreIn, padOut, padOe_n;
    logic [3:0] codes [3] = '{INSTR_BYPASS, 4'h5, 4'h7};
    logic [1:0] expQ [$];
    int n_mismatch = 0;
    int n_compared = 0;
    always #50 sys_clk = ~sys_clk;
    bsctap_top #(.NUM_IO(NIO), .FIFO_DEPTH(32)) bsctap_top_inst (.sys_clk(sys_clk),
        .reset_n(reset_n), .pins(pins), .tdo(tdo), .tdoOe_n(tdoOe_n), .coreOut(coreOut),
        .coreOe(coreOe), .coreIn(coreIn), .padIn(padIn), .padOut(padOut), .padOe_n(padOe_n),
        .testReset(testReset));
    bsctap_host_model host (.sys_clk(sys_clk), .tdo(tdo), .tdoOe_n(tdoOe_n), .pins(pins),
        .seen(seen), .seenVal(seenVal));
    task automatic check(input string what, input logic [31:0] seenV, input logic [31:0] expV);
        n_compared++;
        if (seenV !== expV)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, expV, seenV);
        end
    endtask : check
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    always @(posedge sys_clk)
    begin
        if (seen === 1'b1)
        begin
            if (expQ.size() == 0)
                check("tdo unexpected", 32'h1, 32'h0);
            else
                check("tdo", 32'(seenVal), 32'(expQ.pop_front()));
        end
    end
    // from idle: select, capture, shift n bits, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
        input logic [63:0] dexp, input logic chk);
        host.tick(1'b1, 1'b0, 1'b0);
        if (ir)
            host.tick(1'b1, 1'b0, 1'b0);
        host.tick(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            if (chk)
                expQ.push_back({1'b0, dexp[i]});
            host.tick(1'b0, (i == 0) ? 1'b0 : din[i-1], chk);
        end
        host.tick(1'b1, din[n-1], 1'b0);
        host.tick(1'b1, 1'b0, 1'b0);
        host.tick(1'b0, 1'b0, 1'b0);
    endtask : scan
    initial
    begin
        #1ms;
        n_mismatch++;
        $display("watchdog expired");
        give_verdict();
    end
    initial
    begin
        logic [63:0] din;
        logic [63:0] cells;
        void'($urandom(37308));
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        check("power-up reset", 32'(testReset), 32'h1);
        host.tick(1'b0, 1'b0, 1'b0);
        din = {$urandom, $urandom};
        scan(1'b0, ID_WIDTH, din, IDV, 1'b1);
        $display("test identification done");
        foreach (codes[k])
        begin
            din = {$urandom, $urandom};
            scan(1'b1, IR_WIDTH, {60'h0, codes[k]}, {60'h0, IR_CAPTURE}, 1'b1);
            scan(1'b0, 12, din, {din[62:0], 1'b0}, 1'b1);
        end
        $display("test bypass done");
        padIn = NIO'($urandom);
        coreOut = NIO'($urandom);
        coreOe = NIO'($urandom);
        for (int i = 0; i < NIO; i++)
            cells[3*i +: 3] = {coreOe[i], coreOut[i], padIn[i]};
        scan(1'b1, IR_WIDTH, {60'h0, INSTR_SAMPLE}, {60'h0, IR_CAPTURE}, 1'b1);
        scan(1'b0, BSR, {$urandom, $urandom}, cells, 1'b1);
        scan(1'b1, IR_WIDTH, {60'h0, INSTR_EXTEST}, {60'h0, IR_CAPTURE}, 1'b1);
        din = {$urandom, $urandom};
        scan(1'b0, BSR, din, din, 1'b0);
        // update lands after the last tick returns, pads one cycle later
        repeat (3) @(negedge sys_clk);
        for (int i = 0; i < NIO; i++)
        begin
            check("pad out", 32'(padOut[i]), 32'(din[3*i+1]));
            check("pad oe_n", 32'(padOe_n[i]), 32'(!din[3*i+2]));
        end
        $display("test boundary done");
        host.tick(1'b1, 1'b0, 1'b0);
        host.tick(1'b0, 1'b0, 1'b0);
        host.tick(1'b0, 1'b0, 1'b0);
        repeat (4) host.tick(1'b1, 1'b0, 1'b0);
        check("early reset", 32'(testReset), 32'h0);
        host.tick(1'b1, 1'b0, 1'b0);
        repeat (8) @(negedge sys_clk);
        check("tms reset", 32'(testReset), 32'h1);
        check("pads released", 32'(padOut), 32'(coreOut));
        $display("test tms reset done");
        host.tick(1'b0, 1'b0, 1'b0);
        scan(1'b1, IR_WIDTH, {60'h0, INSTR_BYPASS}, {60'h0, IR_CAPTURE}, 1'b1);
        host.hold_trst(8);
        @(negedge sys_clk);
        check("trst reset", 32'(testReset), 32'h1);
        host.tick(1'b0, 1'b0, 1'b0);
        scan(1'b0, ID_WIDTH, {$urandom, $urandom}, IDV, 1'b1);
        check("queue empty", 32'(expQ.size()), 32'h0);
        $display("test trst done");
        give_verdict();
    end
endmodule : bsctap_top_tb_top
